// ===== rtl/lstc_top.sv
// loop suspend counter, continue counter, registers and interrupt
// assumes one-cycle strobes from a plain register master, read data one cycle later
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`default_nettype none

// Behaviour
// - suspend register: enable, init, read-only count
// - starts or resume reload suspend count
// - enabled loop, nonzero count: decrement, branch
// - enabled loop, zero count: suspend execution
// - alternate mode: last-loop leaves counter alone
// - continue register: init high, count low
// - enabled continue counter reloads on starts
// - both enables: decrement every clock
// - zero: pulse one cycle, reload init
// - pulse resumes only when select set
// - internal pulse acts like external pin
module lstc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // sequencer events
    input wire lstc_pkg::lstc_seq_t seq,
    // sequencer answers
    output logic loop_branch,
    output logic suspend_evt,
    output logic resume_evt,
    output logic continue_pulse,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic sus_en_q;
    logic [7:0] sus_init_q;
    logic [7:0] sus_cnt_q;
    logic [7:0] sus_cnt_d;
    logic [15:0] con_init_q;
    lstc_pkg::lstc_ctrl_t ctrl_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic branch_q;
    logic suspend_q;
    logic resume_q;
    logic irq_q;
    logic resume_d;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire sel_sus = (reg_addr == lstc_pkg::LSTC_OFF_SUSPEND);
    wire sel_con = (reg_addr == lstc_pkg::LSTC_OFF_CONTINUE);
    wire sel_ctrl = (reg_addr == lstc_pkg::LSTC_OFF_CTRL);
    wire sel_stat = (reg_addr == lstc_pkg::LSTC_OFF_IRQ_STATUS);
    wire sel_mask = (reg_addr == lstc_pkg::LSTC_OFF_IRQ_MASK);
    wire wr_sus = reg_write & sel_sus;
    wire wr_con = reg_write & sel_con;
    wire wr_ctrl = reg_write & sel_ctrl;
    wire wr_stat = reg_write & sel_stat;
    wire wr_mask = reg_write & sel_mask;

    // ------------------------------------------------------------
    // continue counter
    // ------------------------------------------------------------
    wire start_evt = seq.start_r | seq.start_s;
    wire [15:0] con_cnt;
    wire int_pulse;

    lstc_continue_cnt u_cont (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start_evt(start_evt),
        .counter_enable(ctrl_q.continue_counter_enable),
        .engine_enable(ctrl_q.engine_enable),
        .count_init(con_init_q),
        .count_value(con_cnt),
        .pulse(int_pulse)
    );

    // ------------------------------------------------------------
    // resume and loop decisions
    // ------------------------------------------------------------
    // internal pulse is ored with the pin, so both resume the same way
    wire cont_any = seq.ext_continue | int_pulse;
    assign resume_d = cont_any & ctrl_q.suspend_resume_select;
    // last-loop in alternate mode bypasses the suspend counter
    wire alt_skip = seq.loop_last & ctrl_q.alternate_address_mode_enable;
    wire loop_counted = seq.loop_op & sus_en_q & ~alt_skip;
    wire sus_zero = (sus_cnt_q == 8'h00);
    wire do_branch = loop_counted & ~sus_zero;
    wire do_suspend = loop_counted & sus_zero;
    wire [7:0] sus_dec = sus_cnt_q - 8'h01;

    always_comb begin
        sus_cnt_d = sus_cnt_q;
        if (start_evt || resume_d) begin
            sus_cnt_d = sus_init_q;
        end else if (do_branch) begin
            sus_cnt_d = sus_dec;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] rd_sus = {sus_en_q, 7'h00, sus_init_q, 8'h00, sus_cnt_q};
    wire [31:0] rd_con = {con_init_q, con_cnt};
    wire [31:0] rd_ctrl = {28'h0000000, ctrl_q.alternate_address_mode_enable,
        ctrl_q.suspend_resume_select, ctrl_q.continue_counter_enable, ctrl_q.engine_enable};
    wire [31:0] rd_stat = {29'h0, irq_stat_q};
    wire [31:0] rd_mask = {29'h0, irq_mask_q};
    wire [31:0] rd_mux = sel_sus ? rd_sus :
                         sel_con ? rd_con :
                         sel_ctrl ? rd_ctrl :
                         sel_stat ? rd_stat :
                         sel_mask ? rd_mask : 32'h00000000;

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    wire [2:0] irq_set = {int_pulse, resume_d, do_suspend};
    wire [2:0] irq_clr = wr_stat ? reg_wdata[2:0] : 3'h0;
    // set wins over a clear in the same cycle
    wire [2:0] irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
    wire irq_d = |(irq_stat_d & irq_mask_q);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sus_en_q <= 1'b0;
            sus_init_q <= lstc_pkg::LSTC_SUS_RST;
            sus_cnt_q <= lstc_pkg::LSTC_SUS_RST;
            con_init_q <= lstc_pkg::LSTC_CON_RST;
            ctrl_q <= lstc_pkg::LSTC_CTRL_RST;
            irq_mask_q <= lstc_pkg::LSTC_IRQ_RST;
        end else begin
            sus_cnt_q <= sus_cnt_d;
            if (wr_sus) begin
                sus_en_q <= reg_wdata[lstc_pkg::LSTC_SUS_EN_BIT];
                sus_init_q <= reg_wdata[lstc_pkg::LSTC_SUS_INIT_LSB +: 8];
            end
            if (wr_con) begin
                con_init_q <= reg_wdata[lstc_pkg::LSTC_CON_INIT_LSB +: 16];
            end
            if (wr_ctrl) begin
                ctrl_q.engine_enable <= reg_wdata[lstc_pkg::LSTC_CTRL_ENGINE_BIT];
                ctrl_q.continue_counter_enable <= reg_wdata[lstc_pkg::LSTC_CTRL_CONT_EN_BIT];
                ctrl_q.suspend_resume_select <= reg_wdata[lstc_pkg::LSTC_CTRL_SELECT_BIT];
                ctrl_q.alternate_address_mode_enable <= reg_wdata[lstc_pkg::LSTC_CTRL_ALT_BIT];
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_q <= lstc_pkg::LSTC_IRQ_RST;
            irq_q <= 1'b0;
            rdata_q <= 32'h00000000;
            branch_q <= 1'b0;
            suspend_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= irq_d;
            rdata_q <= reg_read ? rd_mux : 32'h00000000;
            branch_q <= do_branch;
            suspend_q <= do_suspend;
            resume_q <= resume_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign loop_branch = branch_q;
    assign suspend_evt = suspend_q;
    assign resume_evt = resume_q;
    assign continue_pulse = int_pulse;
    assign irq = irq_q;

endmodule

`default_nettype wire

// ===== rtl/lstc_pkg.sv
// package for the loop suspend and test continue counter block
// assumes a 32-bit register port with word byte addresses
`default_nettype none

package lstc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LSTC_OFF_SUSPEND = 8'h00;
    localparam logic [7:0] LSTC_OFF_CONTINUE = 8'h04;
    localparam logic [7:0] LSTC_OFF_CTRL = 8'h08;
    localparam logic [7:0] LSTC_OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] LSTC_OFF_IRQ_MASK = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LSTC_SUS_EN_BIT = 31;
    localparam int LSTC_SUS_INIT_LSB = 16;
    localparam int LSTC_SUS_VAL_LSB = 0;
    localparam int LSTC_CON_INIT_LSB = 16;
    localparam int LSTC_CON_VAL_LSB = 0;
    localparam int LSTC_CTRL_ENGINE_BIT = 0;
    localparam int LSTC_CTRL_CONT_EN_BIT = 1;
    localparam int LSTC_CTRL_SELECT_BIT = 2;
    localparam int LSTC_CTRL_ALT_BIT = 3;
    localparam int LSTC_IRQ_SUSPEND_BIT = 0;
    localparam int LSTC_IRQ_RESUME_BIT = 1;
    localparam int LSTC_IRQ_PULSE_BIT = 2;
    localparam int LSTC_IRQ_W = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LSTC_SUS_RST = 8'h00;
    localparam logic [15:0] LSTC_CON_RST = 16'h0000;
    localparam logic [3:0] LSTC_CTRL_RST = 4'h0;
    localparam logic [2:0] LSTC_IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic start_r;
        logic start_s;
        logic loop_op;
        logic loop_last;
        logic ext_continue;
    } lstc_seq_t;

    typedef struct packed {
        logic engine_enable;
        logic continue_counter_enable;
        logic suspend_resume_select;
        logic alternate_address_mode_enable;
    } lstc_ctrl_t;

endpackage

`default_nettype wire

// ===== rtl/lstc_continue_cnt.sv
// free running continue down counter with internal pulse
// assumes start events are one-cycle pulses on ref_clk
`default_nettype none

module lstc_continue_cnt (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // control
    input wire logic start_evt,
    input wire logic counter_enable,
    input wire logic engine_enable,
    input wire logic [15:0] count_init,
    // state
    output logic [15:0] count_value,
    output logic pulse
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic pulse_q;
    logic pulse_d;
    wire run = counter_enable & engine_enable;
    wire at_zero = (cnt_q == 16'h0000);
    wire [15:0] dec = cnt_q - 16'h0001;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        // a zero init re-arms only once the pulse has dropped, so the pulse stays one cycle
        if (start_evt && counter_enable) begin
            cnt_d = count_init;
        end else if (run && at_zero && !pulse_q) begin
            cnt_d = count_init;
            pulse_d = 1'b1;
        end else if (run && !at_zero) begin
            cnt_d = dec;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= lstc_pkg::LSTC_CON_RST;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign count_value = cnt_q;
    assign pulse = pulse_q;

endmodule

`default_nettype wire

// ===== bench/lstc_top_chk.sv
// port checker for the counter block
// assumes it is bound to lstc_top, one clock domain
`default_nettype none

module lstc_top_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // sequencer
    input wire lstc_pkg::lstc_seq_t seq,
    input wire logic loop_branch,
    input wire logic suspend_evt,
    input wire logic resume_evt,
    input wire logic continue_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    unmapped_zero_a: assert property ($past(reg_read && reg_addr > 8'h10) |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    sus_reserved_a: assert property ($past(reg_read && reg_addr == 8'h00) |->
        reg_rdata[30:24] == 7'h00 && reg_rdata[15:8] == 8'h00)
        else $error("reserved suspend bits set");
    branch_cause_a: assert property (loop_branch |-> $past(seq.loop_op))
        else $error("branch without loop op");
    suspend_cause_a: assert property (suspend_evt |-> $past(seq.loop_op))
        else $error("suspend without loop op");
    answer_excl_a: assert property (!(loop_branch && suspend_evt))
        else $error("branch and suspend together");
    resume_cause_a: assert property (resume_evt |-> $past(seq.ext_continue) || $past(continue_pulse))
        else $error("resume without continue");
    pulse_once_a: assert property (continue_pulse |=> !continue_pulse)
        else $error("continue pulse too long");
endmodule

bind lstc_top lstc_top_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .seq(seq), .loop_branch(loop_branch), .suspend_evt(suspend_evt),
    .resume_evt(resume_evt), .continue_pulse(continue_pulse));

`default_nettype wire

// ===== bench/tb_lstc_top.sv
// self-checking bench for the counter block
// assumes lstc_top with its checker bound beside it
`default_nettype none

module tb_lstc_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata, rdv, hits;
    lstc_pkg::lstc_seq_t seq = '0;
    logic loop_branch, suspend_evt, resume_evt, continue_pulse, irq;
    int num_errors = 0;
    int checked = 0;
    int n;

    always #20 ref_clk = ~ref_clk;

    lstc_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .seq(seq),
        .loop_branch(loop_branch), .suspend_evt(suspend_evt), .resume_evt(resume_evt),
        .continue_pulse(continue_pulse), .irq(irq));

    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge ref_clk) reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input bit cmp = 1'b1);
        @(posedge ref_clk) {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge ref_clk) reg_read <= 1'b0;
        #1 rdv = reg_rdata;
        if (cmp) chk(reg_rdata, exp);
    endtask
    // one sequencer pulse, then the branch, suspend and resume answers
    task automatic op(input lstc_pkg::lstc_seq_t s, input logic [2:0] exp);
        @(posedge ref_clk) seq <= s;
        @(posedge ref_clk) seq <= '0;
        #1 chk({loop_branch, suspend_evt, resume_evt}, exp);
    endtask
    task automatic stop_test;
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    // ----
    // tests
    // ----
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h80ff_0000);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'hffff_0000);
        wr(8'h14, 32'hffff_ffff);
        rd(8'h14, 32'h0);
        $display("test registers end");
        wr(8'h00, 32'h8002_0000);
        op(5'h10, 3'b000);
        rd(8'h00, 32'h8002_0002);
        op(5'h04, 3'b100);
        op(5'h04, 3'b100);
        op(5'h04, 3'b010);
        rd(8'h00, 32'h8002_0000);
        rd(8'h0c, 32'h1);
        chk(irq, 1'b0);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b1);
        wr(8'h0c, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq, 1'b0);
        rd(8'h0c, 32'h0);
        $display("test suspend end");
        wr(8'h08, 32'h4);
        op(5'h08, 3'b000);
        op(5'h04, 3'b100);
        op(5'h01, 3'b001);
        rd(8'h00, 32'h8002_0002);
        wr(8'h08, 32'h0);
        op(5'h01, 3'b000);
        wr(8'h00, 32'h0003_0000);
        op(5'h10, 3'b000);
        op(5'h04, 3'b000);
        rd(8'h00, 32'h0003_0003);
        wr(8'h08, 32'h8);
        wr(8'h00, 32'h8001_0000);
        op(5'h10, 3'b000);
        op(5'h06, 3'b000);
        rd(8'h00, 32'h8001_0001);
        op(5'h04, 3'b100);
        op(5'h06, 3'b000);
        op(5'h04, 3'b010);
        $display("test resume end");
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0003_0000);
        wr(8'h08, 32'h6);
        op(5'h10, 3'b000);
        rd(8'h04, 32'h0003_0003);
        wr(8'h08, 32'h7);
        n = 0;
        while (continue_pulse !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        @(posedge ref_clk);
        #1 chk(resume_evt, 1'b1);
        n = 1;
        while (continue_pulse !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n, 4);
        for (int i = 0; i < 2; i++) begin
            wr(8'h08, i ? 32'h6 : 32'h5);
            rd(8'h04, 32'h0003_0001);
            hits = 32'h0;
            repeat (10) begin
                @(posedge ref_clk);
                #1 hits = hits + continue_pulse;
            end
            chk(hits, 32'h0);
            rd(8'h04, rdv);
        end
        rd(8'h0c, 32'h7);
        chk(irq, 1'b1);
        wr(8'h0c, 32'h6);
        rd(8'h0c, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
        rd(8'h04, 32'h0000_0001);
        $display("test continue end");
        stop_test();
    end
endmodule

`default_nettype wire
